/* File: core/flash_quirks_pkg.sv */
// Package: register map, field layout and reset values of the flash quirk block
package flash_quirks_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL     = 12'h000; // Erase command and target
    localparam logic [11:0] OFF_STATUS   = 12'h004; // Erase and debug status
    localparam logic [11:0] OFF_PROG     = 12'h008; // Program word in target sector-bank
    localparam logic [11:0] OFF_BCFG     = 12'h00c; // Boot configuration
    localparam logic [11:0] OFF_UNLOCK   = 12'h010; // Debug unlock sequence
    localparam logic [11:0] OFF_BOOT     = 12'h014; // Boot loader status
    localparam logic [11:0] OFF_POWER    = 12'h018; // Power-cycle emulation
    localparam logic [11:0] OFF_RDPROT   = 12'h040; // Read protect 0..15
    localparam logic [11:0] OFF_PGPROT   = 12'h080; // Program protect 0..15

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_CMD_LSB     = 0;  // Command code, 2 bits
    localparam int CTRL_SECT_LSB    = 4;  // Sector-bank index, 6 bits
    localparam int BCFG_NWF_BIT     = 31; // Not-written flag
    localparam int BCFG_DHI_BIT     = 1;  // Upper debug-control bit
    localparam int BCFG_DLO_BIT     = 0;  // Lower debug-control bit
    localparam int WORD_IN_LINE_BIT = 0;  // Word index within last line

    // Reserved bits of boot configuration (all but flag, debug bits, key field)
    localparam logic [31:0] BCFG_RSVD_MASK = 32'h7fff00fc;
    localparam logic [31:0] BCFG_RESET     = 32'hffffffff;

    // Unlock key written to the unlock register
    localparam logic [31:0] UNLOCK_KEY     = 32'h0000a5a5;
    localparam logic [1:0]  UNLOCK_RUNS    = 2'h2;

    // Number of protect registers, lower committed half
    localparam int PROT_REGS = 16;
    localparam int PROT_KEEP = 8;
    localparam logic [31:0] PROT_RESET = 32'hffffffff;

    // Erase timing
    localparam int ERASE_TIME_NS = 200;
    localparam int CLK_PERIOD_NS = 20;
    localparam int ERASE_CYCLES  = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Commands
    localparam logic [1:0] CMD_NONE   = 2'h0;
    localparam logic [1:0] CMD_SECTOR = 2'h1;
    localparam logic [1:0] CMD_MASS   = 2'h2;
    localparam logic [1:0] CMD_TOGGLE = 2'h3;

    // Erase engine states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_BUSY  = 3'b010,
        ST_DONE  = 3'b100
    } erase_state_e;

endpackage

/* File: core/erase_if.sv */
// Interface: erase request and answer between top and erase engine
`timescale 1ns/10ps
interface erase_if;
    logic       start;     // One-cycle erase request
    logic [1:0] cmd;       // Erase kind
    logic       busy;      // Engine working
    logic       done;      // One-cycle completion pulse
    logic       restored;  // Last erase left flash all ones

    modport top (output start, output cmd, input busy, input done, input restored);
    modport eng (input start, input cmd, output busy, output done, output restored);
endinterface

/* File: core/erase_engine.sv */
// Erase engine: timed erase that decides whether flash returns to all ones
`timescale 1ns/10ps
module erase_engine #(
    parameter int CYCLES = flash_quirks_pkg::ERASE_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    erase_if.eng      bus,
    input  wire logic only_first_words, // Only first two last-line words programmed
    input  wire logic any_first_words   // Any first-two last-line word programmed
);

    // ------------------------------------------------------------
    // State and counter
    // ------------------------------------------------------------
    flash_quirks_pkg::erase_state_e state_reg;  // Current state
    flash_quirks_pkg::erase_state_e state_next; // Next state
    logic [7:0]                     cnt_reg;    // Erase time counter
    logic                           rest_reg;   // Restore outcome
    logic [1:0]                     cmd_reg;    // Latched command

    wire logic cnt_end = (cnt_reg == 8'(CYCLES - 1)); // Erase time over
    // Sector erase fails only in the lone-word case; mass kinds fail whenever words sit there
    wire logic sect_ok = ~only_first_words;
    wire logic mass_ok = ~any_first_words;
    wire logic outcome = (cmd_reg == flash_quirks_pkg::CMD_SECTOR) ? sect_ok : mass_ok;

    // Next-state decode
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            flash_quirks_pkg::ST_IDLE: if (bus.start) state_next = flash_quirks_pkg::ST_BUSY;
            flash_quirks_pkg::ST_BUSY: if (cnt_end) state_next = flash_quirks_pkg::ST_DONE;
            flash_quirks_pkg::ST_DONE: state_next = flash_quirks_pkg::ST_IDLE;
            default:                   state_next = flash_quirks_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= flash_quirks_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Counter and command latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            cmd_reg <= 2'h0;
        end else if (state_reg == flash_quirks_pkg::ST_IDLE) begin
            cnt_reg <= 8'h00;
            if (bus.start) cmd_reg <= bus.cmd;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // Outcome captured at end of erase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rest_reg <= 1'b1;
        end else if ((state_reg == flash_quirks_pkg::ST_BUSY) && cnt_end) begin
            rest_reg <= outcome;
        end
    end

    assign bus.busy     = (state_reg != flash_quirks_pkg::ST_IDLE);
    assign bus.done     = (state_reg == flash_quirks_pkg::ST_DONE);
    assign bus.restored = rest_reg;

endmodule

/* File: core/debug_lock.sv */
// Debug lock: commits lock from boot configuration and counts unlock runs
`timescale 1ns/10ps
module debug_lock (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic commit,    // Boot configuration committed this cycle
    input  wire logic nwf,       // Not-written flag of committed value
    input  wire logic dhi,       // Upper debug-control bit
    input  wire logic dlo,       // Lower debug-control bit
    input  wire logic unlock,    // One complete unlock sequence seen
    output logic      locked,    // Debugger access locked
    output logic [1:0] runs      // Unlock runs counted so far
);

    // ------------------------------------------------------------
    // Lock state
    // ------------------------------------------------------------
    logic       lock_reg; // Lock flag
    logic [1:0] runs_reg; // Completed unlock runs

    wire logic lock_cfg = ~nwf & ~dhi & dlo; // Locking combination
    wire logic last_run = (runs_reg == flash_quirks_pkg::UNLOCK_RUNS - 2'h1);

    // Lock set on commit, released only on second run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_reg <= 1'b0;
            runs_reg <= 2'h0;
        end else if (commit && lock_cfg) begin
            lock_reg <= 1'b1;
            runs_reg <= 2'h0;
        end else if (lock_reg && unlock) begin
            if (last_run) begin
                lock_reg <= 1'b0;
                runs_reg <= 2'h0;
            end else begin
                runs_reg <= runs_reg + 2'h1;
            end
        end
    end

    assign locked = lock_reg;
    assign runs   = runs_reg;

endmodule

/* File: core/flash_quirks.sv */
// Top: APB register file for erase, boot configuration and protection quirks
//
// Function
// - Lone first last-line words survive every erase
// - Mass erases still leave those words unerased
// - Debug-disabled commit locks beyond one unlock
// - Cleared reserved boot bits block code execution
// - Upper eight protect registers lost on power
`timescale 1ns/10ps
module flash_quirks #(
    parameter int SECTORS = 64 // Sector-bank count
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             debug_locked,  // Debugger access locked
    output logic             boot_execute   // Boot loader may jump to loaded code
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic acc     = psel & penable;        // Access phase
    wire logic wr      = acc & pwrite;          // Write strobe
    wire logic rd      = acc & ~pwrite;         // Read phase
    wire logic sel_ctl = (paddr == flash_quirks_pkg::OFF_CTRL);
    wire logic sel_st  = (paddr == flash_quirks_pkg::OFF_STATUS);
    wire logic sel_pg  = (paddr == flash_quirks_pkg::OFF_PROG);
    wire logic sel_bc  = (paddr == flash_quirks_pkg::OFF_BCFG);
    wire logic sel_ul  = (paddr == flash_quirks_pkg::OFF_UNLOCK);
    wire logic sel_bt  = (paddr == flash_quirks_pkg::OFF_BOOT);
    wire logic sel_pw  = (paddr == flash_quirks_pkg::OFF_POWER);
    wire logic sel_rp  = (paddr[11:6] == flash_quirks_pkg::OFF_RDPROT[11:6]) && (paddr[1:0] == 2'h0);
    wire logic sel_pp  = (paddr[11:6] == flash_quirks_pkg::OFF_PGPROT[11:6]) && (paddr[1:0] == 2'h0);
    wire logic [3:0] pidx = paddr[5:2];         // Protect register index
    wire logic mapped  = sel_ctl | sel_st | sel_pg | sel_bc | sel_ul | sel_bt | sel_pw | sel_rp | sel_pp;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [5:0]  sect_reg;                 // Target sector-bank
    logic [1:0]  wmask_reg;                // Programmed first-two last-line words
    logic        other_reg;                // Another word programmed
    logic [31:0] boot_config_reg;          // Committed boot configuration
    logic        bc_commit_reg;            // Commit pulse to lock logic
    logic        boot_exec_reg;            // Execution permitted after boot load
    logic [31:0] rdprot_reg [flash_quirks_pkg::PROT_REGS];  // Read protect
    logic [31:0] pgprot_reg [flash_quirks_pkg::PROT_REGS];  // Program protect
    logic [31:0] prdata_reg;               // Read data
    logic        perr_reg;                 // Error response
    logic [1:0]  unlock_runs;              // Runs counted by lock logic

    // ------------------------------------------------------------
    // Erase engine link
    // ------------------------------------------------------------
    erase_if eif ();

    wire logic [1:0] wcmd = pwdata[flash_quirks_pkg::CTRL_CMD_LSB +: 2];
    wire logic erase_go = wr & sel_ctl & ~eif.busy & (wcmd != flash_quirks_pkg::CMD_NONE);
    assign eif.start = erase_go;
    assign eif.cmd   = wcmd;

    // Only first-two last-line words programmed, nothing else
    wire logic only_first = (wmask_reg != 2'h0) & ~other_reg;
    wire logic any_first  = (wmask_reg != 2'h0);

    erase_engine #(
        .CYCLES (flash_quirks_pkg::ERASE_CYCLES)
    ) u_erase (
        .pclk             (pclk),
        .presetn          (presetn),
        .bus              (eif.eng),
        .only_first_words (only_first),
        .any_first_words  (any_first)
    );

    // ------------------------------------------------------------
    // Boot configuration fields
    // ------------------------------------------------------------
    wire logic not_written_flag    = boot_config_reg[flash_quirks_pkg::BCFG_NWF_BIT];
    wire logic debug_ctl_upper_bit = boot_config_reg[flash_quirks_pkg::BCFG_DHI_BIT];
    wire logic debug_ctl_lower_bit = boot_config_reg[flash_quirks_pkg::BCFG_DLO_BIT];
    // Any reserved bit cleared blocks the jump to loaded code
    wire logic rsvd_ok = ((boot_config_reg & flash_quirks_pkg::BCFG_RSVD_MASK)
                          == flash_quirks_pkg::BCFG_RSVD_MASK);
    wire logic unlock_hit = wr & sel_ul & (pwdata == flash_quirks_pkg::UNLOCK_KEY);

    debug_lock u_lock (
        .pclk    (pclk),
        .presetn (presetn),
        .commit  (bc_commit_reg),
        .nwf     (not_written_flag),
        .dhi     (debug_ctl_upper_bit),
        .dlo     (debug_ctl_lower_bit),
        .unlock  (unlock_hit),
        .locked  (debug_locked),
        .runs    (unlock_runs)
    );

    // Power cycle emulated by a write to the power register
    wire logic power_cycle = wr & sel_pw & pwdata[0];

    // ------------------------------------------------------------
    // Erase bookkeeping: programmed-word tracking
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sect_reg  <= 6'h00;
            wmask_reg <= 2'h0;
            other_reg <= 1'b0;
        end else if (eif.done && eif.restored) begin
            wmask_reg <= 2'h0;
            other_reg <= 1'b0;
        end else if (eif.done) begin
            // Affected words stay programmed; other words clear
            other_reg <= 1'b0;
        end else if (wr && sel_ctl && !eif.busy) begin
            sect_reg <= pwdata[flash_quirks_pkg::CTRL_SECT_LSB +: 6];
        end else if (wr && sel_pg) begin
            // pwdata[1] marks a last-line first-two word, [0] selects which
            if (pwdata[1]) begin
                wmask_reg[pwdata[flash_quirks_pkg::WORD_IN_LINE_BIT]] <= 1'b1;
            end else begin
                other_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Boot configuration commit and boot status
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_config_reg <= flash_quirks_pkg::BCFG_RESET;
            bc_commit_reg   <= 1'b0;
            boot_exec_reg   <= 1'b1;
        end else begin
            bc_commit_reg <= wr & sel_bc;
            if (wr && sel_bc) begin
                boot_config_reg <= pwdata;
            end
            if (power_cycle) begin
                boot_exec_reg <= rsvd_ok;
            end
        end
    end

    // ------------------------------------------------------------
    // Protect registers: upper half forgets across power cycle
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < flash_quirks_pkg::PROT_REGS; gi++) begin : g_prot
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rdprot_reg[gi] <= flash_quirks_pkg::PROT_RESET;
                    pgprot_reg[gi] <= flash_quirks_pkg::PROT_RESET;
                end else if (power_cycle && (gi >= flash_quirks_pkg::PROT_KEEP)) begin
                    rdprot_reg[gi] <= flash_quirks_pkg::PROT_RESET;
                    pgprot_reg[gi] <= flash_quirks_pkg::PROT_RESET;
                end else if (wr && (pidx == 4'(gi))) begin
                    // Protect bits only clear (commit sets protection)
                    if (sel_rp) rdprot_reg[gi] <= rdprot_reg[gi] & pwdata;
                    if (sel_pp) pgprot_reg[gi] <= pgprot_reg[gi] & pwdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire logic [31:0] st_word = {24'h000000, unlock_runs, debug_locked, 2'h0,
                                 eif.restored, eif.busy, any_first};
    wire logic [31:0] ctl_word = {22'h000000, sect_reg, 2'h0, 2'h0};
    wire logic [31:0] rd_word =
        sel_ctl ? ctl_word :
        sel_st  ? st_word :
        sel_bc  ? boot_config_reg :
        sel_bt  ? {31'h00000000, boot_exec_reg} :
        sel_rp  ? rdprot_reg[pidx] :
        sel_pp  ? pgprot_reg[pidx] : 32'h00000000;

    // Registered read data and error flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            perr_reg   <= 1'b0;
        end else if (psel && !penable) begin
            prdata_reg <= rd_word;
            perr_reg   <= ~mapped;
        end
    end

    assign prdata       = prdata_reg;
    assign pready       = 1'b1;
    assign pslverr      = acc & perr_reg;
    assign boot_execute = boot_exec_reg;

endmodule

/* File: verif/flash_quirks_checker.sv */
// Checker: port-level assertions for the flash quirk block
`timescale 1ns/10ps
module flash_quirks_checker #(
    parameter int SECTORS = 64 // Sector-bank count
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        debug_locked,
    input wire logic        boot_execute
);
    // ------------------------------------------------------------
    // Access decode and shadow state
    // ------------------------------------------------------------
    logic [31:0] bcfg_reg;                                         // Shadow of boot configuration
    logic [1:0]  unl_reg;                                          // Unlock runs seen while locked
    wire logic   acc       = psel && penable;                      // Access phase
    wire logic   wr        = acc && pwrite;                        // Write takes effect
    wire logic   aligned   = paddr[1:0] == 2'h0;                   // Word aligned
    wire logic   mapped    = (paddr <= flash_quirks_pkg::OFF_POWER)
                             || (paddr >= flash_quirks_pkg::OFF_RDPROT && paddr <= 12'h0bc);
    wire logic   bcfg_hit  = paddr == flash_quirks_pkg::OFF_BCFG; // Boot configuration address
    wire logic   rd_bcfg   = acc && !pwrite && bcfg_hit;           // Boot configuration read
    wire logic   lock_wr   = wr && bcfg_hit && !pwdata[31] && !pwdata[1] && pwdata[0];
    wire logic   unlock_wr = wr && paddr == flash_quirks_pkg::OFF_UNLOCK && pwdata == flash_quirks_pkg::UNLOCK_KEY;
    wire logic   power_wr  = wr && paddr == flash_quirks_pkg::OFF_POWER && pwdata[0];
    wire logic   rsvd_ok   = &(bcfg_reg | ~flash_quirks_pkg::BCFG_RSVD_MASK); // Reserved bits all one

    // Shadow follows every boot configuration write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcfg_reg <= flash_quirks_pkg::BCFG_RESET;
        end else if (wr && bcfg_hit) begin
            bcfg_reg <= pwdata;
        end
    end

    // Count unlock runs only while locked, saturating at two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unl_reg <= 2'h0;
        end else if (!debug_locked) begin
            unl_reg <= 2'h0;
        end else if (unlock_wr && unl_reg != 2'h2) begin
            unl_reg <= unl_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_lock_cmd;
        lock_wr;
    endsequence
    sequence s_power_cmd;
        power_wr;
    endsequence

    a_ready_high: assert property (pready)
        else $error("pready low outside reset");
    a_err_unmapped: assert property (acc && aligned && !mapped |-> pslverr)
        else $error("unmapped access without error");
    a_ok_mapped: assert property (acc && aligned && mapped |-> !pslverr)
        else $error("mapped access flagged as error");
    a_lock_set: assert property (s_lock_cmd |-> ##[1:3] debug_locked)
        else $error("debug lock not set after locking commit");
    a_lock_cause: assert property ($rose(debug_locked) |-> $past(lock_wr) || $past(lock_wr, 2) || $past(lock_wr, 3))
        else $error("debug lock set without locking commit");
    a_unlock_twice: assert property ($fell(debug_locked) |-> unl_reg == 2'h2)
        else $error("debug lock released before two unlock runs");
    a_boot_follow: assert property (s_power_cmd |=> boot_execute == $past(rsvd_ok))
        else $error("boot execute does not follow reserved bits");
    a_boot_hold: assert property ($changed(boot_execute) |-> $past(power_wr))
        else $error("boot execute changed without power cycle");
    a_bcfg_read: assert property (rd_bcfg |-> prdata == bcfg_reg)
        else $error("boot configuration read back wrong");
endmodule

bind flash_quirks flash_quirks_checker #(.SECTORS(SECTORS)) u_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_locked(debug_locked), .boot_execute(boot_execute)
);

/* File: verif/flash_quirks_bench.sv */
// Testbench: random and corner-case checks of the flash quirk block
`timescale 1ns/10ps
module flash_quirks_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite;   // Clock, reset, bus controls
    logic [11:0] paddr, a;                               // Bus address, scratch address
    logic [31:0] pwdata, prdata, rd, v;                  // Bus data, read result, scratch
    logic [3:0]  pstrb;                                  // Byte strobes
    logic        pready, pslverr, debug_locked, boot_execute, err; // Design outputs, error seen
    logic [5:0]  sect;                                   // Target sector-bank
    logic [31:0] prot_exp [0:31];                        // Expected protect values
    int          n_mismatch, samples_checked, seed, b;   // Counters, seed, bit index

    flash_quirks DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .debug_locked(debug_locked), .boot_execute(boot_execute));

    // Clock at 50 MHz
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Verdict and end of run
    task automatic stop_test;
        $display("counts: %0d mismatches in %0d comparisons", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) chk(32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read and compare
    task automatic rdc(input logic [11:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(rd, exp);
    endtask

    // Start an erase, poll until idle, compare the restored flag
    task automatic erase(input logic [1:0] cmd, input logic exp);
        int k;
        apb(1'b1, flash_quirks_pkg::OFF_CTRL, {22'h0, sect, 2'h0, cmd});
        repeat (3) @(posedge pclk);
        k = 0;
        do begin
            apb(1'b0, flash_quirks_pkg::OFF_STATUS, 32'h0);
            k++;
        end while (rd[1] !== 1'b0 && k < 40);
        chk({k >= 40, 30'h0, rd[2]}, {31'h0, exp});
    endtask

    // Watchdog against a hung run
    initial begin
        #200000;
        $display("watchdog expired");
        n_mismatch++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        presetn = 1'b0;
        n_mismatch = 0;
        samples_checked = 0;
        seed = 67;
        for (int i = 0; i < 32; i++) prot_exp[i] = flash_quirks_pkg::PROT_RESET;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(flash_quirks_pkg::OFF_BCFG, flash_quirks_pkg::BCFG_RESET);
        chk({31'h0, boot_execute}, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset and decode done");
        // Erase sequences on one random sector-bank
        sect = 6'($random(seed));
        apb(1'b1, flash_quirks_pkg::OFF_PROG, {30'h0, 1'b1, 1'($random(seed))});
        erase(flash_quirks_pkg::CMD_SECTOR, 1'b0);
        apb(1'b1, flash_quirks_pkg::OFF_PROG, $random(seed) & 32'hfffffffd);
        erase(flash_quirks_pkg::CMD_SECTOR, 1'b1);
        erase(flash_quirks_pkg::CMD_MASS, 1'b1);
        erase(flash_quirks_pkg::CMD_TOGGLE, 1'b1);
        apb(1'b1, flash_quirks_pkg::OFF_PROG, 32'h3);
        apb(1'b1, flash_quirks_pkg::OFF_PROG, 32'h0);
        erase(flash_quirks_pkg::CMD_MASS, 1'b0);
        erase(flash_quirks_pkg::CMD_TOGGLE, 1'b0);
        apb(1'b1, flash_quirks_pkg::OFF_PROG, 32'h0);
        erase(flash_quirks_pkg::CMD_SECTOR, 1'b1);
        $display("test erase done");
        // Every combination of the three lock bits
        for (int i = 0; i < 8; i++) begin
            v = flash_quirks_pkg::BCFG_RSVD_MASK | ($random(seed) & 32'h0000ff00) | {i[2], 29'h0, i[1], i[0]};
            apb(1'b1, flash_quirks_pkg::OFF_BCFG, v);
            rdc(flash_quirks_pkg::OFF_BCFG, v);
            @(negedge pclk);
            chk({31'h0, debug_locked}, {31'h0, i == 1});
            if (i == 1) begin
                apb(1'b1, flash_quirks_pkg::OFF_UNLOCK, flash_quirks_pkg::UNLOCK_KEY);
                repeat (3) @(negedge pclk);
                chk({31'h0, debug_locked}, 32'h1);
                apb(1'b1, flash_quirks_pkg::OFF_UNLOCK, flash_quirks_pkg::UNLOCK_KEY);
                repeat (3) @(negedge pclk);
                chk({31'h0, debug_locked}, 32'h0);
            end
        end
        $display("test debug lock done");
        // Boot with reserved bits whole, one cleared, whole again
        do b = $random(seed) & 31; while (!flash_quirks_pkg::BCFG_RSVD_MASK[b]);
        for (int j = 0; j < 3; j++) begin
            v = (j == 1) ? ~(32'h1 << b) : flash_quirks_pkg::BCFG_RESET;
            apb(1'b1, flash_quirks_pkg::OFF_BCFG, v);
            apb(1'b1, flash_quirks_pkg::OFF_POWER, 32'h1);
            @(negedge pclk);
            chk({31'h0, boot_execute}, {31'h0, j != 1});
            rdc(flash_quirks_pkg::OFF_BOOT, {31'h0, j != 1});
        end
        $display("test boot done");
        // Protect: commit, power cycle, recommit
        for (int p = 0; p < 3; p++) begin
            if (p == 1) apb(1'b1, flash_quirks_pkg::OFF_POWER, 32'h1);
            for (int i = 0; i < 32; i++) begin
                a = flash_quirks_pkg::OFF_RDPROT + 12'(4 * i);
                if (p == 1 && i % 16 >= 8) prot_exp[i] = flash_quirks_pkg::PROT_RESET;
                if (p != 1) begin
                    v = $random(seed);
                    apb(1'b1, a, v);
                    prot_exp[i] = prot_exp[i] & v;
                end
                rdc(a, prot_exp[i]);
            end
        end
        $display("test protect done");
        stop_test();
    end
endmodule
